// ===== scan_tap_defines.svh
// Constants of the boundary-scan test port: codes, sizes and reset values
`ifndef SCAN_TAP_DEFINES_SVH
`define SCAN_TAP_DEFINES_SVH

// Instruction register
`define IR_LEN        3
`define IR_EXTEST     3'h0
`define IR_INTEST     3'h1
`define IR_SAMPLE     3'h2
`define IR_IDCODE     3'h3
`define IR_BYPASS     3'h7
`define IR_RESET_VAL  3'h1
`define IR_CAPTURE    3'h1

// Identification word
`define ID_LEN        32
`define ID_LSB        1'h1

// Boundary chain layout, positions 35 to 70
`define PIN_COUNT     36
`define IO_PIN_COUNT  4
`define CELL_COUNT    60
`define OUT_PIN_MASK  32'h3FC0C33C
`define CELL_RESET    1'h0

`endif

// ===== scan_tap_pkg.sv
// Types shared by the boundary-scan test port modules
`default_nettype none

package scan_tap_pkg;

    // Test access port controller states
    typedef enum logic [3:0] {
        TLR    = 4'h0,
        RTI    = 4'h1,
        SEL_DR = 4'h2,
        CAP_DR = 4'h3,
        SH_DR  = 4'h4,
        EX1_DR = 4'h5,
        PA_DR  = 4'h6,
        EX2_DR = 4'h7,
        UPD_DR = 4'h8,
        SEL_IR = 4'h9,
        CAP_IR = 4'hA,
        SH_IR  = 4'hB,
        EX1_IR = 4'hC,
        PA_IR  = 4'hD,
        EX2_IR = 4'hE,
        UPD_IR = 4'hF
    } tap_state_t;

    // Data register picked by the instruction
    typedef enum logic [2:0] {
        SEL_EXTEST = 3'h0,
        SEL_INTEST = 3'h1,
        SEL_SAMPLE = 3'h2,
        SEL_IDCODE = 3'h3,
        SEL_BYPASS = 3'h4
    } dr_sel_t;

endpackage

`default_nettype wire

// ===== pin_sync.sv
// Two-stage synchroniser for levels from outside the clock domain
`default_nettype none

module pin_sync #(
    parameter int W = 1                 // Number of bits
) (
    input  wire logic         clk,      // System clock
    input  wire logic         srst,     // Synchronous reset
    input  wire logic         ce,       // Clock enable
    input  wire logic [W-1:0] d,        // Asynchronous levels
    output logic      [W-1:0] q         // Synchronised levels
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else if (ce)
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== bscan_chain.sv
// Boundary-scan shift stage and update latches
`default_nettype none
`include "scan_tap_defines.svh"

module bscan_chain #(
    parameter int LEN = 60              // Number of cells
) (
    input  wire logic           clk,    // System clock
    input  wire logic           srst,   // Synchronous reset
    input  wire logic           ce,     // Clock enable
    input  wire logic           cap,    // Capture strobe
    input  wire logic           shift,  // Shift strobe
    input  wire logic           upd,    // Update strobe
    input  wire logic           si,     // Serial in, TDI end
    input  wire logic [LEN-1:0] cap_d,  // Levels to capture
    output logic      [LEN-1:0] sr_q,   // Shift stage, [LEN-1] at TDO
    output logic      [LEN-1:0] upd_q   // Update latches
);

    // Capture, shift toward TDO, or hold
    always_ff @(posedge clk)
    begin
        if (srst)
            sr_q <= {LEN{`CELL_RESET}};
        else if (ce && cap)
            sr_q <= cap_d;
        else if (ce && shift)
            sr_q <= {sr_q[LEN-2:0], si};
    end

    // Latches stay steady while the stage shifts
    always_ff @(posedge clk)
    begin
        if (srst)
            upd_q <= {LEN{`CELL_RESET}};
        else if (ce && upd)
            upd_q <= sr_q;
    end

endmodule

`default_nettype wire

// ===== scan_tap.sv
// Boundary-scan test port: TAP controller, instructions and data registers
// ****************************************************************
// ****************************************************************
`default_nettype none
`include "scan_tap_defines.svh"

module scan_tap #(
    parameter logic [3:0]  ID_VERSION = 4'h1,     // Arbitrary value
    parameter logic [15:0] ID_PART    = 16'hA5C3, // Arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h155,  // Arbitrary value
    parameter int          NPIN       = `PIN_COUNT,
    parameter int          NCELL      = `CELL_COUNT
) (
    input  wire logic            CLOCK,  // System clock, 250 MHz
    input  wire logic            SRST,   // Synchronous reset
    input  wire logic            CE,     // Clock enable
    input  wire logic            TCK,    // Test clock pin
    input  wire logic            TMS,    // Test mode select pin
    input  wire logic            TDI,    // Test data in pin
    output logic                 TDO,    // Test data out level
    output logic                 TDO_OE, // Test data out enable
    input  wire logic [NPIN-1:0] PIN_I,  // Pad levels
    input  wire logic [NPIN-1:0] SYS_O,  // Core output data
    input  wire logic [NPIN-1:0] SYS_OE, // Core output enables
    output logic      [NPIN-1:0] PAD_O,  // Pad output data
    output logic      [NPIN-1:0] PAD_OE, // Pad output enables
    output logic      [NPIN-1:0] CORE_I  // Levels seen by the core
);

    // ************************************************************
    // Layout of the chain
    // ************************************************************

    localparam int IOPINS            = `IO_PIN_COUNT;
    localparam int PCM_FRAME_SYNC_IN = 34;
    localparam int PCM_DATA_CLOCK_IN = 35;
    localparam int PROBE_OUT_PIN     = 6;

    // Output pin, counted after the two-way pins
    function automatic bit pin_out(input int p);
        logic [31:0] mask;
        mask = `OUT_PIN_MASK;
        return (p >= IOPINS) ? mask[p-IOPINS] : 1'b0;
    endfunction

    // Cells a pin owns
    function automatic int pin_cells(input int p);
        return (p < IOPINS) ? 3 : (pin_out(p) ? 2 : 1);
    endfunction

    // First cell of a pin, counted from the TDI end
    function automatic int cell_base(input int p);
        int sum;
        sum = 0;
        for (int i = 0; i < p; i++)
            sum = sum + pin_cells(i);
        return sum;
    endfunction

    // Instruction to data register
    function automatic scan_tap_pkg::dr_sel_t decode(input logic [2:0] ir);
        case (ir)
            `IR_EXTEST: return scan_tap_pkg::SEL_EXTEST;
            `IR_INTEST: return scan_tap_pkg::SEL_INTEST;
            `IR_SAMPLE: return scan_tap_pkg::SEL_SAMPLE;
            `IR_IDCODE: return scan_tap_pkg::SEL_IDCODE;
            default:    return scan_tap_pkg::SEL_BYPASS;
        endcase
    endfunction

    // Pins with a pad driver: two-way and output-only
    function automatic logic [NPIN-1:0] drive_mask();
        logic [NPIN-1:0] m;
        m = '0;
        for (int p = 0; p < NPIN; p++)
            m[p] = (p < IOPINS) | pin_out(p);
        return m;
    endfunction

    localparam int              PROBE_OUT_CELL = cell_base(PROBE_OUT_PIN);
    localparam int              DCLK_CELL      = cell_base(PCM_DATA_CLOCK_IN);
    localparam int              FSYNC_CELL     = cell_base(PCM_FRAME_SYNC_IN);
    localparam logic [NPIN-1:0] DRV_MASK       = drive_mask();

    // ************************************************************
    // Pin sampling
    // ************************************************************

    logic [2:0]      jtag_s;
    logic [NPIN-1:0] pin_s;
    logic            tck_s;
    logic            tms_s;
    logic            tdi_s;
    logic            tck_last_q;
    logic            tck_rise;
    logic            tck_fall;

    pin_sync #(.W(3)) u_jtag_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .ce   (CE),
        .d    ({TCK, TMS, TDI}),
        .q    (jtag_s)
    );

    pin_sync #(.W(NPIN)) u_pad_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .ce   (CE),
        .d    (PIN_I),
        .q    (pin_s)
    );

    // TCK edges found by the fast clock
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            tck_last_q <= 1'h0;
        else if (CE)
            tck_last_q <= tck_s;
    end

    assign tck_s    = jtag_s[2];
    assign tms_s    = jtag_s[1];
    assign tdi_s    = jtag_s[0];
    assign tck_rise = tck_s & ~tck_last_q;
    assign tck_fall = ~tck_s & tck_last_q;

    // ************************************************************
    // Controller
    // ************************************************************

    scan_tap_pkg::tap_state_t state_q;
    scan_tap_pkg::tap_state_t state_d;

    // Next state from TMS
    always_comb
    begin
        case (state_q)
            scan_tap_pkg::TLR:
                state_d = tms_s ? scan_tap_pkg::TLR : scan_tap_pkg::RTI;
            scan_tap_pkg::RTI:
                state_d = tms_s ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
            scan_tap_pkg::SEL_DR:
                state_d = tms_s ? scan_tap_pkg::SEL_IR : scan_tap_pkg::CAP_DR;
            scan_tap_pkg::CAP_DR, scan_tap_pkg::SH_DR:
                state_d = tms_s ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SH_DR;
            scan_tap_pkg::EX1_DR:
                state_d = tms_s ? scan_tap_pkg::UPD_DR : scan_tap_pkg::PA_DR;
            scan_tap_pkg::PA_DR:
                state_d = tms_s ? scan_tap_pkg::EX2_DR : scan_tap_pkg::PA_DR;
            scan_tap_pkg::EX2_DR:
                state_d = tms_s ? scan_tap_pkg::UPD_DR : scan_tap_pkg::SH_DR;
            scan_tap_pkg::SEL_IR:
                state_d = tms_s ? scan_tap_pkg::TLR : scan_tap_pkg::CAP_IR;
            scan_tap_pkg::CAP_IR, scan_tap_pkg::SH_IR:
                state_d = tms_s ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SH_IR;
            scan_tap_pkg::EX1_IR:
                state_d = tms_s ? scan_tap_pkg::UPD_IR : scan_tap_pkg::PA_IR;
            scan_tap_pkg::PA_IR:
                state_d = tms_s ? scan_tap_pkg::EX2_IR : scan_tap_pkg::PA_IR;
            scan_tap_pkg::EX2_IR:
                state_d = tms_s ? scan_tap_pkg::UPD_IR : scan_tap_pkg::SH_IR;
            scan_tap_pkg::UPD_DR, scan_tap_pkg::UPD_IR:
                state_d = tms_s ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
            default:
                state_d = scan_tap_pkg::TLR;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            state_q <= scan_tap_pkg::TLR;
        else if (CE && tck_rise)
            state_q <= state_d;
    end

    // ************************************************************
    // Instruction register
    // ************************************************************

    logic [`IR_LEN-1:0]    ir_q;
    logic [`IR_LEN-1:0]    irsr_q;
    scan_tap_pkg::dr_sel_t sel;

    // Shift stage, LSB leaves first
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            irsr_q <= `IR_CAPTURE;
        else if (CE && tck_rise && state_q == scan_tap_pkg::CAP_IR)
            irsr_q <= `IR_CAPTURE;
        else if (CE && tck_rise && state_q == scan_tap_pkg::SH_IR)
            irsr_q <= {tdi_s, irsr_q[`IR_LEN-1:1]};
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            ir_q <= `IR_RESET_VAL;
        else if (CE && state_q == scan_tap_pkg::TLR)
            ir_q <= `IR_IDCODE;
        else if (CE && tck_fall && state_q == scan_tap_pkg::UPD_IR)
            ir_q <= irsr_q;
    end

    assign sel = decode(ir_q);

    // ************************************************************
    // Data registers
    // ************************************************************

    logic              bs_sel;
    logic              ext;
    logic              intest;
    logic              cap_dr;
    logic              sh_dr;
    logic              upd_dr;
    logic [NCELL-1:0]  cap_w;
    logic [NCELL-1:0]  chain_sr;
    logic [NCELL-1:0]  chain_upd;
    logic [`ID_LEN-1:0] id_q;
    logic              bp_q;

    assign ext    = (sel == scan_tap_pkg::SEL_EXTEST);
    assign intest = (sel == scan_tap_pkg::SEL_INTEST);
    assign bs_sel = ext | intest | (sel == scan_tap_pkg::SEL_SAMPLE);
    assign cap_dr = tck_rise & (state_q == scan_tap_pkg::CAP_DR);
    assign sh_dr  = tck_rise & (state_q == scan_tap_pkg::SH_DR);
    assign upd_dr = tck_fall & (state_q == scan_tap_pkg::UPD_DR);

    // chain from position 35 to 70
    bscan_chain #(.LEN(NCELL)) u_chain (
        .clk   (CLOCK),
        .srst  (SRST),
        .ce    (CE),
        .cap   (cap_dr & bs_sel),
        .shift (sh_dr & bs_sel),
        .upd   (upd_dr & bs_sel),
        .si    (tdi_s),
        .cap_d (cap_w),
        .sr_q  (chain_sr),
        .upd_q (chain_upd)
    );

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            id_q <= '0;
            bp_q <= 1'h0;
        end
        else if (CE && cap_dr)
        begin
            id_q <= {ID_VERSION, ID_PART, ID_MAKER, `ID_LSB};
            bp_q <= 1'h0;
        end
        else if (CE && sh_dr)
        begin
            id_q <= {tdi_s, id_q[`ID_LEN-1:1]};
            bp_q <= tdi_s;
        end
    end

    // ************************************************************
    // Pin cells
    // ************************************************************

    logic [NPIN-1:0] pad_o_w;
    logic [NPIN-1:0] pad_oe_w;
    logic [NPIN-1:0] core_w;

    // cells per pin type, input cell nearest TDI
    for (genvar p = 0; p < NPIN; p++)
    begin : g_pin
        localparam int  B   = cell_base(p);
        localparam bit  IO  = (p < IOPINS);
        localparam bit  OP  = pin_out(p);
        localparam int  OB  = IO ? B + 1 : B;
        if (!OP)
        begin : g_in
            // pad capture outside INTEST, where the latch drives both core and capture
            assign cap_w[B]  = intest ? chain_upd[B] : pin_s[p];
            assign core_w[p] = intest ? chain_upd[B] : pin_s[p];
        end
        else
        begin : g_noin
            assign core_w[p] = 1'h0;
        end
        if (IO || OP)
        begin : g_out
            assign cap_w[OB]     = SYS_O[p];
            assign cap_w[OB + 1] = SYS_OE[p];
            // pads follow latches only in EXTEST
            assign pad_o_w[p]  = ext ? chain_upd[OB] : SYS_O[p];
            assign pad_oe_w[p] = ext ? chain_upd[OB + 1] : SYS_OE[p];
        end
        else
        begin : g_noout
            assign pad_o_w[p]  = 1'h0;
            assign pad_oe_w[p] = 1'h0;
        end
    end

    // Registered pads, one system cycle behind the cells
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            PAD_O  <= '0;
            PAD_OE <= '0;
            CORE_I <= '0;
        end
        else if (CE)
        begin
            PAD_O  <= pad_o_w;
            PAD_OE <= pad_oe_w;
            CORE_I <= core_w;
        end
    end

    // ************************************************************
    // Test data out
    // ************************************************************

    logic shifting;
    logic dr_out;

    assign shifting = (state_q == scan_tap_pkg::SH_DR) |
                      (state_q == scan_tap_pkg::SH_IR);
    assign dr_out   = bs_sel ? chain_sr[NCELL-1] :
                      (sel == scan_tap_pkg::SEL_IDCODE) ? id_q[0] : bp_q;

    // change on falling TCK, released outside shifting
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            TDO    <= 1'h0;
            TDO_OE <= 1'h0;
        end
        else if (CE && tck_fall)
        begin
            TDO    <= (state_q == scan_tap_pkg::SH_IR) ? irsr_q[0] : dr_out;
            TDO_OE <= shifting;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    tms_walk_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && tck_rise && state_q == scan_tap_pkg::UPD_DR && tms_s) |=>
        state_q == scan_tap_pkg::SEL_DR)
        else $error("update-DR with TMS high did not select DR");

    ir_decode_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (ir_q[2] || ir_q == `IR_BYPASS) |-> sel == scan_tap_pkg::SEL_BYPASS)
        else $error("unused code did not select bypass");

    ext_drive_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && upd_dr && ext ##1 CE) |=>
        PAD_O[PROBE_OUT_PIN] == $past(chain_sr[PROBE_OUT_CELL], 2))
        else $error("EXTEST update did not reach output pin");

    ext_capture_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && cap_dr && ext) |=>
        chain_sr[DCLK_CELL] == $past(pin_s[PCM_DATA_CLOCK_IN]) &&
        chain_sr[FSYNC_CELL] == $past(pin_s[PCM_FRAME_SYNC_IN]))
        else $error("EXTEST capture missed input pin level");

    int_apply_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && upd_dr && intest ##1 CE) |=>
        CORE_I[PCM_DATA_CLOCK_IN] == $past(chain_sr[DCLK_CELL], 2))
        else $error("INTEST update did not reach core input");

    int_capture_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && cap_dr && intest) |=>
        chain_sr[PROBE_OUT_CELL] == $past(SYS_O[PROBE_OUT_PIN]))
        else $error("INTEST capture missed core output");

    ir_reset_a: assert property (@(posedge CLOCK)
        SRST |=> ir_q == `IR_INTEST)
        else $error("instruction register reset value wrong");

    tlr_load_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && state_q == scan_tap_pkg::TLR) |=> ir_q == `IR_IDCODE)
        else $error("test-logic-reset did not load IDCODE");

    sample_pass_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && !ext && $past(!ext)) |=> PAD_O == ($past(SYS_O) & DRV_MASK))
        else $error("pads disturbed outside EXTEST");

    id_word_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && cap_dr && sel == scan_tap_pkg::SEL_IDCODE) |=>
        id_q == {ID_VERSION, ID_PART, ID_MAKER, 1'h1})
        else $error("identification word wrong");

    bypass_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && sh_dr && sel == scan_tap_pkg::SEL_BYPASS) |=>
        bp_q == $past(tdi_s))
        else $error("bypass stage did not take TDI");

    chain_zero_a: assert property (@(posedge CLOCK)
        SRST |=> (chain_sr == '0) && (chain_upd == '0))
        else $error("chain cells not zero after reset");

    tdo_enable_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (CE && tck_fall) |=> TDO_OE == $past(shifting))
        else $error("TDO enable outside shift states");

endmodule

`default_nettype wire

// ===== tester_model.sv
// Behavioural boundary-scan tester that drives the test port pins
`default_nettype none

module tester_model (
    input  wire logic clk,   // Bench clock, paces the test clock
    input  wire logic tdo_i, // Port data level
    input  wire logic oe_i,  // Port data enable
    output logic      tck,   // Test clock
    output logic      tms,   // Mode select
    output logic      tdi    // Data in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last_q = 1'h0; // Last level seen on the data line

    // Idle: clock low, mode select high keeps the port in reset
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // 32 ns clock, mode set at the fall
    task automatic bit_io(input logic m, input logic d,
                          output logic o, output logic e);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #1 tck = 1'h1;
        repeat (4) @(posedge clk);
        // Sampled late in the high half: data only moves after a fall
        e = oe_i;
        // A released line shows the inverse of its last level
        o = oe_i ? tdo_i : ~last_q;
        last_q = o;
        #1 tck = 1'h0;
    endtask
endmodule

`default_nettype wire

// ===== boundary_scan_tap_test.sv
// Self-checking bench of the boundary-scan test port
`default_nettype none
`include "scan_tap_defines.svh"

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    n_errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module boundary_scan_tap_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0]  VER = 4'h6;     // Arbitrary value
    localparam logic [15:0] PRT = 16'h3C5A; // Arbitrary value
    localparam logic [10:0] MKR = 11'h2B7;  // Arbitrary value

    logic        CLOCK  = 1'h0;
    logic        SRST   = 1'h1;
    logic        CE     = 1'h1;
    logic        TCK, TMS, TDI, TDO, TDO_OE;
    logic [35:0] PIN_I  = 36'h0;
    logic [35:0] SYS_O  = 36'h0;
    logic [35:0] SYS_OE = 36'h0;
    logic [35:0] PAD_O, PAD_OE, CORE_I;
    logic [127:0] vi, vo;
    int          n_errors = 0;
    int          total_checks = 0;
    int          ci[36];  // Input cell of each pin
    int          co[36];  // Output cell; enable cell follows it

    // 250 MHz clock
    always #2 CLOCK = ~CLOCK;

    scan_tap #(.ID_VERSION(VER), .ID_PART(PRT), .ID_MAKER(MKR)) uut (
        .CLOCK(CLOCK), .SRST(SRST), .CE(CE), .TCK(TCK), .TMS(TMS),
        .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .PIN_I(PIN_I),
        .SYS_O(SYS_O), .SYS_OE(SYS_OE), .PAD_O(PAD_O), .PAD_OE(PAD_OE),
        .CORE_I(CORE_I));

    tester_model tm (.clk(CLOCK), .tdo_i(TDO), .oe_i(TDO_OE), .tck(TCK),
                     .tms(TMS), .tdi(TDI));

    // Pin kind: 1 input, 2 output, 3 two-way
    function automatic int kind(input int p);
        if (p < 4)
            return 3;
        if (p inside {[6:9], 12, 13, 18, 19, [26:33]})
            return 2;
        return 1;
    endfunction

    // One test clock, enable compared with what the state implies
    task automatic step(input logic m, input logic d, input logic x,
                        output logic o);
        logic e;
        tm.bit_io(m, d, o, e);
        `CHK("TDO_OE", x, e)
    endtask

    // Full IR or DR scan from Run-Test/Idle back to it
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] v, output logic [127:0] r);
        logic o;
        step(1'h1, 1'h0, 1'h0, o);
        if (ir)
            step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
        for (int i = 0; i < n; i++)
            step(i == n - 1, v[i], 1'h1, r[i]);
        step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
    endtask

    // Five highs reach reset whatever the state, then idle
    task automatic tap_reset;
        logic o;
        repeat (5) step(1'h1, 1'h0, 1'h0, o);
        step(1'h0, 1'h0, 1'h0, o);
    endtask

    // Identification word shifted out after reset
    task automatic id_read;
        scan(1'h0, 32, vi, vo);
        `CHK("idcode", {VER, PRT, MKR, 1'h1}, vo[31:0])
    endtask

    // Pads and core inputs; m 0 external, 1 internal, 2 functional
    task automatic pin_check(input int m);
        for (int p = 0; p < 36; p++)
        begin
            logic ho, hi;
            ho = kind(p) > 1;
            hi = kind(p) != 2;
            `CHK("PAD_O", ho ? (m == 0 ? vi[59 - co[p]] : SYS_O[p]) : 1'h0,
                 PAD_O[p])
            `CHK("PAD_OE", ho ? (m == 0 ? vi[58 - co[p]] : SYS_OE[p]) : 1'h0,
                 PAD_OE[p])
            `CHK("CORE_I", hi ? (m == 1 ? vi[59 - ci[p]] : PIN_I[p]) : 1'h0,
                 CORE_I[p])
        end
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge CLOCK);
        n_errors++;
        test_done();
    end

    // Main sequence
    initial
    begin
        int c;
        int len;
        void'($urandom(32'h768833AF));
        vi = {$urandom, $urandom, $urandom, $urandom};
        c = 0;
        for (int p = 0; p < 36; p++)
        begin
            if (kind(p) != 2)
                ci[p] = c++;
            if (kind(p) > 1)
            begin
                co[p] = c;
                c += 2;
            end
        end
        repeat (12) @(posedge CLOCK);
        #1;
        `CHK("reset", 109'h0, {TDO_OE, PAD_O, PAD_OE, CORE_I})
        SRST = 1'h0;
        repeat (4) @(posedge CLOCK);
        #1;
        tap_reset();
        id_read();
        // Every code: captured IR value and length of the chosen path
        for (int k = 0; k < 8; k++)
        begin
            scan(1'h1, 3, 128'(k), vo);
            `CHK("ir_capture", 3'h1, vo[2:0])
            len = (k == 3) ? 32 : (k < 3) ? 60 : 1;
            vi = {$urandom, $urandom, $urandom, $urandom};
            scan(1'h0, len + 8, vi, vo);
            if (k == 3)
                `CHK("id_word", {VER, PRT, MKR, 1'h1}, vo[31:0])
            for (int i = 0; i < 8; i++)
                `CHK("dr_path", vi[i], vo[i + len])
        end
        // Preload under snapshot, then external and internal test
        for (int m = 0; m < 2; m++)
        begin
            PIN_I = 36'({$urandom, $urandom});
            SYS_O = 36'({$urandom, $urandom});
            SYS_OE = 36'({$urandom, $urandom});
            vi = {$urandom, $urandom, $urandom, $urandom};
            scan(1'h1, 3, 128'(`IR_SAMPLE), vo);
            scan(1'h0, 60, vi, vo);
            pin_check(2);
            scan(1'h1, 3, 128'(m), vo);
            pin_check(m);
            scan(1'h0, 60, vi, vo);
            for (int p = 0; p < 36; p++)
            begin
                if (kind(p) != 2)
                    `CHK("cap_in", m ? vi[59 - ci[p]] : PIN_I[p],
                         vo[59 - ci[p]])
                if (kind(p) > 1)
                    `CHK("cap_out", {SYS_O[p], SYS_OE[p]},
                         {vo[59 - co[p]], vo[58 - co[p]]})
            end
        end
        tap_reset();
        id_read();
        test_done();
    end
endmodule

`default_nettype wire
